// [hdl/scpmc_pkg.sv]
package scpmc_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] SYS_CLK_SELECT_OFS = 8'h00; // system_clock_select
  localparam logic [7:0] HS_OSC_CONTROL_OFS = 8'h04; // hs_osc_control
  localparam logic [7:0] HALT_CONTROL_OFS = 8'h08; // Halt flags; writing bit 1 clears power-down
  localparam logic [7:0] STATUS_OFS = 8'h0C; // Watchdog count, mode and active clock select
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int SEL_LSB = 5;
  localparam int HS_IDLE_BIT = 1;
  localparam int LS_IDLE_BIT = 0;
  localparam int FREQ_LSB = 2;
  localparam int STABLE_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam logic [7:0] SYS_CLK_SELECT_RST = 8'h00;
  localparam logic [7:0] HS_OSC_CONTROL_RST = 8'h01;
  localparam logic [2:0] SEL_LS_CODE = 3'h7; // Code that picks the low-speed clock
  // ****************************************
  // Timing
  // ****************************************
  localparam int STABLE_CYCLES = 16; // Default oscillator settle count
  localparam int WDT_WIDTH = 16; // Watchdog counter width
  // Power modes
  typedef enum logic [2:0] {
    SCPMC_RUN, SCPMC_SLEEP, SCPMC_IDLE_LS, SCPMC_IDLE_BOTH, SCPMC_IDLE_HS
  } scpmc_mode_type;
endpackage

// [hdl/scpmc_top.sv]
`timescale 1ns/100ps
// Contract
// - Select code picks divided fast or slow clock
// - Fast idle bit keeps fast oscillator at halt
// - Slow idle bit keeps slow oscillator at halt
// - Watchdog enable forces slow oscillator on
// - Frequency field selects 4, 8, 12 MHz
// - New frequency applies only once stable
// - Enable or frequency change clears stable, then sets
// - Enable bit runs fast oscillator
// - Unimplemented bits read zero
// - Fast return: software checks stable flag
// - Both idle bits low gives sleep
// - Only slow idle bit gives slow-only idle
// - Both idle bits give both-clock idle
// - Only fast idle bit gives fast-only idle
// - Halt sets power-down, clears time-out flag
// - Halt preserves memory, registers, ports
// - Halt clears watchdog counter
module scpmc_top #(
  parameter int STABLE_COUNT = scpmc_pkg::STABLE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HALT_REQ,
  input wire logic WAKE_REQ,
  input wire logic WDT_ENABLE,
  input wire logic WDT_TIMEOUT,
  input wire logic LS_OSC_READY,
  output logic SYS_CLK_EN,
  output logic HS_OSC_RUN,
  output logic LS_OSC_RUN,
  output logic [1:0] HS_FREQ_APPLIED,
  output logic CPU_RUN,
  output logic WDT_CLEAR,
  output scpmc_pkg::scpmc_mode_type MODE
);
  import scpmc_pkg::*;

  // ****************************************
  // Registers and state
  // ****************************************
  logic [2:0] sel_q; // sys_clk_select
  logic hs_idle_enable_q;
  logic ls_idle_enable_q;
  logic [1:0] hs_freq_select_q;
  logic hs_osc_enable_q;
  logic hs_osc_stable_flag_q;
  logic power_down_flag_q;
  logic watchdog_timeout_flag_q;
  logic [15:0] settle_q; // Oscillator settle counter
  logic [2:0] active_sel_q; // Select code the divider really uses
  logic [5:0] div_q; // Free-running divider
  logic [WDT_WIDTH-1:0] wdt_q; // Watchdog count
  scpmc_mode_type mode_q;
  logic wr_en, halt_go, hs_kick, hs_run, ls_run;
  logic [31:0] rdata_d;

  // Access phase strobes; slave answers with zero wait states
  assign wr_en = PSEL && PENABLE && PWRITE;
  // Halt only honoured while running
  assign halt_go = HALT_REQ && (mode_q == SCPMC_RUN);
  // Enable rising or frequency change restarts settling
  assign hs_kick = wr_en && (PADDR == HS_OSC_CONTROL_OFS) &&
                   (PWDATA[ENABLE_BIT] && (!hs_osc_enable_q ||
                    PWDATA[FREQ_LSB+1:FREQ_LSB] != hs_freq_select_q));

  // Tick of the divider for a given code
  function automatic logic div_tick(input logic [2:0] code, input logic [5:0] cnt);
    logic [5:0] m;
    m = 6'h3F >> (3'h6 - ((code > 3'h6) ? 3'h6 : code));
    div_tick = ((cnt & m) == m);
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  // Clock select register: all fields read/write
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= SYS_CLK_SELECT_RST[7:5];
      hs_idle_enable_q <= SYS_CLK_SELECT_RST[HS_IDLE_BIT];
      ls_idle_enable_q <= SYS_CLK_SELECT_RST[LS_IDLE_BIT];
    end else if (wr_en && PADDR == SYS_CLK_SELECT_OFS) begin
      sel_q <= PWDATA[SEL_LSB+2:SEL_LSB];
      hs_idle_enable_q <= PWDATA[HS_IDLE_BIT];
      ls_idle_enable_q <= PWDATA[LS_IDLE_BIT];
    end
  end

  // Oscillator control register; stable flag is read-only
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      hs_freq_select_q <= HS_OSC_CONTROL_RST[FREQ_LSB+1:FREQ_LSB];
      hs_osc_enable_q <= HS_OSC_CONTROL_RST[ENABLE_BIT];
    end else if (wr_en && PADDR == HS_OSC_CONTROL_OFS) begin
      hs_freq_select_q <= PWDATA[FREQ_LSB+1:FREQ_LSB];
      hs_osc_enable_q <= PWDATA[ENABLE_BIT];
    end
  end

  // ****************************************
  // Oscillator control
  // ****************************************
  // Fast oscillator runs when enabled, and at halt only if idle bit allows
  assign hs_run = hs_osc_enable_q &&
                  (mode_q == SCPMC_RUN || hs_idle_enable_q);
  // Slow oscillator: running, idle bit, or watchdog keeps it alive
  assign ls_run = (mode_q == SCPMC_RUN) || ls_idle_enable_q || WDT_ENABLE;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      HS_OSC_RUN <= 1'b0;
      LS_OSC_RUN <= 1'b1;
    end else begin
      HS_OSC_RUN <= hs_run;
      LS_OSC_RUN <= ls_run;
    end
  end

  // Settle counter clears stable on kick, sets it after the count.
  // Stopped oscillator drops stable so a later restart resettles.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      settle_q <= '0;
      hs_osc_stable_flag_q <= 1'b0;
    end else if (hs_kick || !hs_run) begin
      settle_q <= '0;
      hs_osc_stable_flag_q <= 1'b0;
    end else if (!hs_osc_stable_flag_q) begin
      if (settle_q == 16'(STABLE_COUNT - 1)) begin
        hs_osc_stable_flag_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 16'h0001;
      end
    end
  end

  // Applied frequency follows the field only once stable
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      HS_FREQ_APPLIED <= HS_OSC_CONTROL_RST[FREQ_LSB+1:FREQ_LSB];
    end else if (hs_osc_stable_flag_q) begin
      HS_FREQ_APPLIED <= hs_freq_select_q;
    end
  end

  // ****************************************
  // System clock generation
  // ****************************************
  // Divider runs always so ratio changes land on a period boundary
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // Code is adopted only at the end of a whole old period, and a switch
  // waits for the target oscillator to be ready, so no short pulse
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      active_sel_q <= SYS_CLK_SELECT_RST[7:5];
    end else if (sel_q != active_sel_q && div_tick(active_sel_q, div_q)) begin
      if (sel_q == SEL_LS_CODE ? LS_OSC_READY : hs_osc_stable_flag_q) begin
        active_sel_q <= sel_q;
      end
    end
  end

  // Clock enable pulse; stopped while halted in sleep or slow-only idle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYS_CLK_EN <= 1'b0;
    end else if (mode_q == SCPMC_SLEEP || mode_q == SCPMC_IDLE_LS) begin
      SYS_CLK_EN <= 1'b0;
    end else if (active_sel_q == SEL_LS_CODE) begin
      SYS_CLK_EN <= LS_OSC_READY && ls_run;
    end else begin
      SYS_CLK_EN <= hs_run && div_tick(active_sel_q, div_q);
    end
  end

  // ****************************************
  // Power mode state
  // ****************************************
  // Halt picks a mode from the idle bits; wake returns to run.
  // Registers are untouched here, so state is preserved over halt.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_q <= SCPMC_RUN;
    end else begin
      case (mode_q)
        SCPMC_RUN: begin
          if (halt_go) begin
            case ({hs_idle_enable_q, ls_idle_enable_q})
              2'b00: mode_q <= SCPMC_SLEEP;
              2'b01: mode_q <= SCPMC_IDLE_LS;
              2'b11: mode_q <= SCPMC_IDLE_BOTH;
              default: mode_q <= SCPMC_IDLE_HS;
            endcase
          end
        end
        default: begin
          if (WAKE_REQ) begin
            mode_q <= SCPMC_RUN;
          end
        end
      endcase
    end
  end

  // CPU runs only outside halt; mode mirrors state
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      CPU_RUN <= 1'b1;
      MODE <= SCPMC_RUN;
    end else begin
      CPU_RUN <= (mode_q == SCPMC_RUN) && !halt_go;
      MODE <= mode_q;
    end
  end

  // Halt flags: time-out set wins over halt clear, so none is lost
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      power_down_flag_q <= 1'b0;
      watchdog_timeout_flag_q <= 1'b0;
    end else begin
      if (halt_go) begin
        power_down_flag_q <= 1'b1;
      end else if (wr_en && PADDR == HALT_CONTROL_OFS && PWDATA[1]) begin
        power_down_flag_q <= 1'b0;
      end
      if (WDT_TIMEOUT) begin
        watchdog_timeout_flag_q <= 1'b1;
      end else if (halt_go) begin
        watchdog_timeout_flag_q <= 1'b0;
      end
    end
  end

  // Watchdog counter clears on halt and keeps counting
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      wdt_q <= '0;
      WDT_CLEAR <= 1'b0;
    end else begin
      WDT_CLEAR <= halt_go;
      if (halt_go) begin
        wdt_q <= '0;
      end else if (WDT_ENABLE) begin
        wdt_q <= wdt_q + WDT_WIDTH'(1);
      end
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  // Unmapped address reads zero and raises the error answer
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (PADDR)
      SYS_CLK_SELECT_OFS: rdata_d = {24'h0, sel_q, 3'h0, hs_idle_enable_q,
                                     ls_idle_enable_q};
      HS_OSC_CONTROL_OFS: rdata_d = {24'h0, 4'h0, hs_freq_select_q,
                                     hs_osc_stable_flag_q, hs_osc_enable_q};
      HALT_CONTROL_OFS: rdata_d = {30'h0, power_down_flag_q, watchdog_timeout_flag_q};
      STATUS_OFS: rdata_d = {wdt_q, 8'h0, 1'b0, mode_q, 1'b0, active_sel_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Answer registered in the setup cycle so access phase sees ready
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && PADDR != SYS_CLK_SELECT_OFS &&
                 PADDR != HS_OSC_CONTROL_OFS && PADDR != HALT_CONTROL_OFS &&
                 PADDR != STATUS_OFS;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rdata_d : 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_halt_sets_pdf: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    halt_go |=> power_down_flag_q && (watchdog_timeout_flag_q == $past(WDT_TIMEOUT)))
    else $error("Halt did not set power-down flag");
  chk_sleep_no_clk: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    halt_go && !hs_idle_enable_q && !ls_idle_enable_q |=> ##1 !SYS_CLK_EN)
    else $error("Clock ran in sleep");
  chk_ls_idle_mode: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    halt_go && !hs_idle_enable_q && ls_idle_enable_q |=> mode_q == SCPMC_IDLE_LS)
    else $error("Wrong slow-only idle mode");
  chk_both_idle_mode: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    halt_go && hs_idle_enable_q && ls_idle_enable_q |=> mode_q == SCPMC_IDLE_BOTH)
    else $error("Wrong both-clock idle mode");
  chk_hs_idle_mode: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    halt_go && hs_idle_enable_q && !ls_idle_enable_q |=> mode_q == SCPMC_IDLE_HS)
    else $error("Wrong fast-only idle mode");
  chk_wdt_forces_ls: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    WDT_ENABLE |=> LS_OSC_RUN)
    else $error("Slow oscillator stopped with watchdog on");
  chk_kick_clears_flag: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    hs_kick |=> !hs_osc_stable_flag_q)
    else $error("Stable flag not cleared on kick");
  chk_wdt_cleared: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    halt_go |=> wdt_q == '0 && WDT_CLEAR)
    else $error("Watchdog not cleared on halt");
  chk_hs_idle_off: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    mode_q != SCPMC_RUN && !hs_idle_enable_q |=> !HS_OSC_RUN)
    else $error("Fast oscillator ran in halt");
  // Frequency, slow clock and settle count guards
  chk_freq_held: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !hs_osc_stable_flag_q |=> HS_FREQ_APPLIED == $past(HS_FREQ_APPLIED))
    else $error("Frequency applied before stable");
  chk_slow_clk_runs: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    active_sel_q == SEL_LS_CODE && mode_q == SCPMC_RUN && LS_OSC_READY |=> SYS_CLK_EN)
    else $error("Slow system clock stopped");
  chk_settle_count: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(hs_osc_stable_flag_q) |-> settle_q == 16'(STABLE_COUNT - 1))
    else $error("Stable flag set at wrong count");
endmodule

// [verif/tb_scpmc_top.sv]
`timescale 1ns/100ps
module tb_scpmc_top;
  import scpmc_pkg::*;
  // ****************************************
  // Bench signals
  // ****************************************
  logic clk; // 10 MHz bench clock
  logic arst_n; // Active-low reset
  logic psel, penable, pwrite, halt, wake, wdt_en, wdt_to, ls_rdy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sys_en, hs_run, ls_run, cpu_run, wdt_clr;
  logic [1:0] freq;
  scpmc_mode_type mode;
  logic [31:0] rd; // Last read word
  logic err; // Last error response
  int mismatches;
  int checks_done;
  // Short settle count keeps the stabilisation waits brief
  scpmc_top #(.STABLE_COUNT(4)) scpmc_top_inst (.CLOCK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .HALT_REQ(halt), .WAKE_REQ(wake),
    .WDT_ENABLE(wdt_en), .WDT_TIMEOUT(wdt_to), .LS_OSC_READY(ls_rdy), .SYS_CLK_EN(sys_en),
    .HS_OSC_RUN(hs_run), .LS_OSC_RUN(ls_run), .HS_FREQ_APPLIED(freq), .CPU_RUN(cpu_run),
    .WDT_CLEAR(wdt_clr), .MODE(mode));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // APB cycle; the request holds until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // Values read just after an edge are the ones sampled at that edge
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n < 20, 1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts system clock ticks over a window
  task automatic count_ticks(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      #1;
      n += sys_en;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    apb(0, SYS_CLK_SELECT_OFS, 0);
    chk(rd, 32'h0, "select reset");
    apb(1, SYS_CLK_SELECT_OFS, 32'hFFFF_FFFF);
    apb(0, SYS_CLK_SELECT_OFS, 0);
    chk(rd, 32'hE3, "select spare bits");
    apb(1, SYS_CLK_SELECT_OFS, 0);
    tick(8);
    apb(0, HS_OSC_CONTROL_OFS, 0);
    chk(rd, 32'h3, "osc control settled");
    apb(1, HS_OSC_CONTROL_OFS, 32'hFFFF_FFFF);
    apb(0, HS_OSC_CONTROL_OFS, 0);
    chk(rd, 32'h0D, "stable cleared on rewrite");
    chk(freq, 2'h0, "old frequency held");
    // Every frequency code in turn, each one a change
    for (int f = 1; f < 5; f++) begin
      apb(1, HS_OSC_CONTROL_OFS, ((f % 4) << FREQ_LSB) | 1);
      tick(8);
      apb(0, HS_OSC_CONTROL_OFS, 0);
      chk(rd, ((f % 4) << FREQ_LSB) | 3, "stable again");
      chk(freq, f % 4, "frequency applied");
    end
    apb(1, HS_OSC_CONTROL_OFS, 0);
    tick(4);
    chk(hs_run, 0, "fast osc off");
    apb(1, HS_OSC_CONTROL_OFS, 1);
    tick(8);
    chk(hs_run, 1, "fast osc on");
    apb(1, 8'h10, 32'hFF);
    chk(err, 1, "unmapped write refused");
    apb(0, 8'h10, 0);
    chk(err, 1, "unmapped read refused");
    chk(rd, 32'h0, "unmapped read data");
    $display("TEST registers done");
  endtask
  task automatic t_clock();
    int n;
    for (int c = 0; c < 7; c++) begin
      apb(1, SYS_CLK_SELECT_OFS, c << SEL_LSB);
      tick(140);
      count_ticks(128, n);
      chk(n >= (128 >> c) - 1 && n <= (128 >> c) + 1, 1, "divider ratio");
    end
    // Slow switch must wait for the slow oscillator
    @(posedge clk) ls_rdy <= 1'b0;
    apb(1, SYS_CLK_SELECT_OFS, 32'(SEL_LS_CODE) << SEL_LSB);
    tick(20);
    apb(0, STATUS_OFS, 0);
    chk(rd[2:0] !== SEL_LS_CODE, 1, "slow switch waits");
    @(posedge clk) ls_rdy <= 1'b1;
    tick(80);
    apb(0, STATUS_OFS, 0);
    chk(rd[2:0], SEL_LS_CODE, "slow switch done");
    apb(1, SYS_CLK_SELECT_OFS, 0);
    tick(80);
    apb(0, STATUS_OFS, 0);
    chk(rd[2:0], 3'h0, "fast return");
    $display("TEST clock select done");
  endtask
  task automatic t_halt(input logic hs, input logic ls, input logic we,
                        input scpmc_mode_type m);
    int wc;
    int ce;
    apb(1, SYS_CLK_SELECT_OFS, {30'h0, hs, ls});
    @(posedge clk);
    wdt_en <= we;
    wdt_to <= 1'b1;
    @(posedge clk) wdt_to <= 1'b0;
    // With we set, let the watchdog count well past the post-halt bound first; with we low it stays stopped
    tick(100);
    apb(0, HALT_CONTROL_OFS, 0);
    chk(rd[0], 1, "time-out flag set");
    @(posedge clk) halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    wc = 0;
    // The restart pulse stands in the cycle right after the halt edge
    repeat (4) begin
      #1;
      wc += wdt_clr;
      @(posedge clk);
    end
    chk(wc, 1, "watchdog restart pulse");
    chk(mode, m, "halt mode");
    chk(cpu_run, 0, "cpu stopped");
    chk(hs_run, hs, "fast osc at halt");
    chk(ls_run, ls | we, "slow osc at halt");
    count_ticks(16, ce);
    if (m == SCPMC_SLEEP) chk(ce, 0, "sleep clock stopped");
    apb(0, HALT_CONTROL_OFS, 0);
    chk(rd[1:0], 2'b10, "halt flags");
    apb(0, STATUS_OFS, 0);
    chk(rd[31:16] < 16'd64, 1, "watchdog restarted");
    apb(0, SYS_CLK_SELECT_OFS, 0);
    chk(rd, {30'h0, hs, ls}, "registers kept");
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    tick(3);
    #1;
    chk({cpu_run, mode}, {1'b1, SCPMC_RUN}, "woken");
    apb(1, HALT_CONTROL_OFS, 32'h2);
    tick(8);
    $display("TEST halt mode %0d done", m);
  endtask
  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic stop_test();
    $display("Counts: %0d mismatches in %0d checks", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {arst_n, psel, penable, pwrite, halt, wake, wdt_en, wdt_to} = 8'h00;
    ls_rdy = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    checks_done = 0;
    tick(8);
    arst_n <= 1'b1;
    t_regs();
    t_clock();
    t_halt(0, 0, 0, SCPMC_SLEEP);
    t_halt(0, 0, 1, SCPMC_SLEEP);
    t_halt(0, 1, 0, SCPMC_IDLE_LS);
    t_halt(1, 1, 0, SCPMC_IDLE_BOTH);
    t_halt(1, 0, 0, SCPMC_IDLE_HS);
    stop_test();
  end
  // Hang guard, well beyond the few thousand cycles the run needs
  initial begin
    #3000000;
    mismatches++;
    stop_test();
  end
endmodule
